/* File: core/delay_if.sv */
// timer request and expiry carrier between the sequencer and its timers
`default_nettype none
interface delay_if;
	logic start;
	logic run;
	logic [31:0] limit;
	logic expired;
	modport owner (output start, output run, output limit, input expired);
	modport timer (input start, input run, input limit, output expired);
endinterface
`default_nettype wire

/* File: core/drive_operating_state_sequencer.sv */
// top of the drive operating state sequencer
`default_nettype none
module drive_operating_state_sequencer
#(
	parameter int SUPPLY_WAIT_CYC = 50_000_000,
	parameter int AUX_DELAY_CYC = 5_000_000,
	parameter int BRAKE_DELAY_CYC = 5_000_000,
	parameter int INCH_CYC = drive_seq_pkg::INCH_DELAY_CYC
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [3:0] controlWord,
	input wire logic switchOnPin,
	input wire logic enablePin,
	input wire logic fastStopPin,
	input wire logic disconnectPin,
	input wire logic [1:0] emergencyStopPin,
	input wire logic contactorCheckbackPin,
	input wire logic fieldReversalBrakePin,
	input wire logic externalFieldOkPin,
	input wire logic external_field_check_input_fn,
	input wire logic contactor_checkback_input_fn,
	input wire logic field_reversal_brake_input_fn,
	input wire logic [drive_seq_pkg::VOLT_W-1:0] armatureVolts,
	input wire logic [drive_seq_pkg::VOLT_W-1:0] fieldVolts,
	input wire logic [drive_seq_pkg::VOLT_W-1:0] nominal_armature_supply_voltage,
	input wire logic [drive_seq_pkg::PCT_W-1:0] undervoltage_threshold_percent,
	input wire logic [drive_seq_pkg::CUR_W-1:0] fieldCurrent,
	input wire logic [drive_seq_pkg::CUR_W-1:0] fieldSetpoint,
	input wire logic [drive_seq_pkg::CUR_W-1:0] rampInputSetpoint,
	input wire logic [drive_seq_pkg::CUR_W-1:0] setpoint_switch_on_threshold,
	input wire logic thyristorCheckSelect,
	input wire logic thyristorCheckDone,
	input wire logic symmetryCheckDone,
	input wire logic auxiliariesOn,
	input wire logic shutdownCmd,
	input wire logic internalShutdown,
	input wire logic inchingActive,
	input wire logic fieldReversalPending,
	input wire logic optimizationRun,
	input wire logic optimizationDone,
	input wire logic peer_link_select_a,
	input wire logic peerTelegramValid,
	input wire logic [15:0] link0_telegram_timeout,
	input wire logic [15:0] link1_telegram_timeout,
	input wire logic link0TelegramValid,
	input wire logic link1TelegramValid,
	input wire logic faultEvent,
	input wire logic [7:0] faultCode,
	output logic [3:0] operating_state_display,
	output logic [2:0] subState,
	output logic [7:0] faultNumber,
	output logic faultLamp,
	output logic fault_output_fn,
	output logic [15:0] drive_status_word,
	output logic runEnable
);
	import drive_seq_pkg::*;
	initial
	begin
		if (SUPPLY_WAIT_CYC < 1 || AUX_DELAY_CYC < 1 || BRAKE_DELAY_CYC < 1 || INCH_CYC < 1)
			$error("delay counts must be at least one cycle");
	end
	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic [10:0] pinRaw, pinS;
	assign pinRaw = {switchOnPin, enablePin, fastStopPin, disconnectPin, emergencyStopPin,
		contactorCheckbackPin, fieldReversalBrakePin, externalFieldOkPin, auxiliariesOn, shutdownCmd};
	sync2 #(.W(11)) u_sync (.clock(clock), .resetn(resetn), .d(pinRaw), .q(pinS));
	logic swOnS, enS, fstopS, discS, contS, frbS, extFieldS, auxS, shutS;
	logic [1:0] estopS;
	assign {swOnS, enS, fstopS, discS, estopS, contS, frbS, extFieldS, auxS, shutS} = pinS;
	// ----------------------------------------
	// thresholds
	// ----------------------------------------
	// cross-multiplying instead of dividing keeps the percentage exact
	function automatic logic above(input logic [VOLT_W-1:0] v, input logic [VOLT_W-1:0] nom,
		input logic [PCT_W-1:0] pct);
		logic [VOLT_W+PCT_W-1:0] lhs;
		logic [VOLT_W+PCT_W-1:0] rhs;
		lhs = (VOLT_W+PCT_W)'(v) * (VOLT_W+PCT_W)'(PCT_FULL);
		rhs = (VOLT_W+PCT_W)'(nom) * (VOLT_W+PCT_W)'(pct);
		above = lhs > rhs;
	endfunction
	logic armOk, fieldCurOk, fieldVoltOk, setpointOk;
	assign armOk = above(armatureVolts, nominal_armature_supply_voltage, undervoltage_threshold_percent);
	assign fieldCurOk = ({1'b0, fieldCurrent} * (CUR_W+1)'(FIELD_HALF_DIV)) > {1'b0, fieldSetpoint}
		&& (!external_field_check_input_fn || extFieldS);
	assign fieldVoltOk = above(fieldVolts, VOLT_W'(FIELD_NOM_V), undervoltage_threshold_percent);
	assign setpointOk = rampInputSetpoint <= setpoint_switch_on_threshold;
	// ----------------------------------------
	// latches and handshakes
	// ----------------------------------------
	logic fsLatch_ff, nxt_fsLatch, fsWithdrawn_ff, nxt_fsWithdrawn;
	logic inhibit_ff, nxt_inhibit, fault_ff, nxt_fault, brakeSeen_ff, nxt_brakeSeen;
	logic link0Seen_ff, nxt_link0Seen, link1Seen_ff, nxt_link1Seen, peerSeen_ff, nxt_peerSeen;
	logic inchPrev_ff, nxt_inchPrev;
	logic [7:0] faultNum_ff, nxt_faultNum;
	logic timeoutFault;
	logic fsActive;
	assign fsActive = fstopS || controlWord[CW_FAST_STOP];
	always_comb
	begin
		nxt_fsLatch = fsLatch_ff;
		nxt_fsWithdrawn = fsWithdrawn_ff;
		if (fsActive)
		begin
			nxt_fsLatch = 1'b1;
			nxt_fsWithdrawn = 1'b0;
		end
		else if (fsLatch_ff && !fsWithdrawn_ff)
			nxt_fsWithdrawn = 1'b1;
		else if (fsLatch_ff && shutS)
		begin
			nxt_fsLatch = 1'b0;
			nxt_fsWithdrawn = 1'b0;
		end
		nxt_inhibit = inhibit_ff;
		if (fsActive || discS || controlWord[CW_DISCONNECT] || fault_ff)
			nxt_inhibit = 1'b1;
		else if (shutS)
			nxt_inhibit = 1'b0;
		nxt_brakeSeen = brakeSeen_ff;
		if (field_reversal_brake_input_fn && frbS)
			nxt_brakeSeen = 1'b1;
		else if (!frbS)
			nxt_brakeSeen = 1'b0;
		nxt_link0Seen = link0Seen_ff || link0TelegramValid;
		nxt_link1Seen = link1Seen_ff || link1TelegramValid;
		nxt_peerSeen = peerSeen_ff || peerTelegramValid;
		nxt_fault = fault_ff || faultEvent || timeoutFault;
		nxt_faultNum = faultNum_ff;
		if (faultEvent && !fault_ff)
			nxt_faultNum = faultCode;
		// hold keeps the withdrawal delay running after the command drops
		nxt_inchPrev = inchingActive || (inchPrev_ff && !inchIf.expired);
	end
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			fsLatch_ff <= 1'b0;
			fsWithdrawn_ff <= 1'b0;
			inhibit_ff <= 1'b1;
			brakeSeen_ff <= 1'b0;
			link0Seen_ff <= 1'b0;
			link1Seen_ff <= 1'b0;
			peerSeen_ff <= 1'b0;
			fault_ff <= 1'b0;
			faultNum_ff <= 8'h00;
			inchPrev_ff <= 1'b0;
		end
		else if (ce)
		begin
			fsLatch_ff <= nxt_fsLatch;
			fsWithdrawn_ff <= nxt_fsWithdrawn;
			inhibit_ff <= nxt_inhibit;
			brakeSeen_ff <= nxt_brakeSeen;
			link0Seen_ff <= nxt_link0Seen;
			link1Seen_ff <= nxt_link1Seen;
			peerSeen_ff <= nxt_peerSeen;
			fault_ff <= nxt_fault;
			faultNum_ff <= nxt_faultNum;
			inchPrev_ff <= nxt_inchPrev;
		end
	end
	// ----------------------------------------
	// timers
	// ----------------------------------------
	delay_if supIf();
	delay_if auxIf();
	delay_if brkIf();
	delay_if inchIf();
	seq_timer u_sup (.clock(clock), .resetn(resetn), .ce(ce), .tmr(supIf.timer));
	seq_timer u_aux (.clock(clock), .resetn(resetn), .ce(ce), .tmr(auxIf.timer));
	seq_timer u_brk (.clock(clock), .resetn(resetn), .ce(ce), .tmr(brkIf.timer));
	seq_timer u_inch (.clock(clock), .resetn(resetn), .ce(ce), .tmr(inchIf.timer));
	// ----------------------------------------
	// state evaluation, highest pending wins
	// ----------------------------------------
	opstate_t st;
	logic waitArm, waitField;
	always_comb
	begin
		st = '{state: ST_RUN, sub: 3'h0};
		if (fault_ff)
			st = '{state: ST_FAULT, sub: 3'h0};
		else if (discS || controlWord[CW_DISCONNECT] || estopS != 2'b00
			|| (peer_link_select_a && !peerSeen_ff)
			|| (link1_telegram_timeout != 16'h0000 && !link1Seen_ff)
			|| (link0_telegram_timeout != 16'h0000 && !link0Seen_ff))
		begin
			st.state = ST_DISC;
			if (discS) st.sub = 3'h0;
			else if (controlWord[CW_DISCONNECT]) st.sub = 3'h1;
			else if (estopS != 2'b00) st.sub = 3'h2;
			else if (peer_link_select_a && !peerSeen_ff) st.sub = 3'h3;
			else if (link1_telegram_timeout != 16'h0000 && !link1Seen_ff) st.sub = 3'h4;
			else st.sub = 3'h5;
		end
		else if (fsActive || fsLatch_ff)
			st = '{state: ST_FSTOP, sub: fstopS ? 3'h0 : (controlWord[CW_FAST_STOP] ? 3'h1 : 3'h2)};
		else if (inhibit_ff)
			st = '{state: ST_INHIB, sub: 3'h0};
		else if (!(swOnS || controlWord[CW_SWITCH_ON]))
			st = '{state: ST_SWON, sub: 3'h0};
		else if (internalShutdown || brakeSeen_ff)
			st = '{state: ST_SWON, sub: 3'h2};
		else if (!auxS || !auxIf.expired)
			st = '{state: ST_PRECON, sub: 3'h0};
		else if (!setpointOk)
			st = '{state: ST_PRECON, sub: 3'h1};
		else if (!armOk)
			st = '{state: ST_ARM, sub: 3'h0};
		else if (!fieldCurOk)
			st = '{state: ST_FIELD, sub: 3'h0};
		else if (!fieldVoltOk)
			st = '{state: ST_FIELD, sub: 3'h1};
		else if (thyristorCheckSelect && !thyristorCheckDone)
			st = '{state: ST_TEST, sub: 3'h0};
		else if (!symmetryCheckDone)
			st = '{state: ST_TEST, sub: 3'h1};
		else if (!enS)
			st = '{state: ST_READY, sub: 3'h1};
		else if (!controlWord[CW_ENABLE])
			st = '{state: ST_READY, sub: 3'h2};
		else if (inchingActive || (inchIf.run && !inchIf.expired))
			st = '{state: ST_READY, sub: 3'h3};
		else if (fieldReversalPending)
			st = '{state: ST_READY, sub: 3'h4};
		else if (optimizationRun && !optimizationDone)
			st = '{state: ST_READY, sub: 3'h5};
		else if (contactor_checkback_input_fn && !contS)
			st = '{state: ST_READY, sub: 3'h6};
		else if (!brkIf.expired)
			st = '{state: ST_READY, sub: 3'h0};
	end
	assign waitArm = st.state == ST_ARM;
	assign waitField = st.state == ST_FIELD;
	// supply timer runs across both waits; expiry is a fault
	assign supIf.start = 1'b0;
	assign supIf.run = waitArm || waitField;
	assign supIf.limit = 32'(SUPPLY_WAIT_CYC);
	assign timeoutFault = supIf.expired && supIf.run;
	assign auxIf.start = 1'b0;
	assign auxIf.run = auxS;
	assign auxIf.limit = 32'(AUX_DELAY_CYC);
	assign inchIf.start = inchingActive;
	assign inchIf.run = inchingActive || inchPrev_ff;
	assign inchIf.limit = 32'(INCH_CYC);
	assign brkIf.start = 1'b0;
	assign brkIf.run = st.state == ST_RUN || (st.state == ST_READY && st.sub == 3'h0);
	assign brkIf.limit = 32'(BRAKE_DELAY_CYC);
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic [3:0] disp_ff;
	logic [2:0] sub_ff;
	logic run_ff;
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			disp_ff <= ST_FAULT;
			sub_ff <= 3'h0;
			run_ff <= 1'b0;
		end
		else if (ce)
		begin
			disp_ff <= st.state;
			sub_ff <= st.sub;
			run_ff <= st.state == ST_RUN;
		end
	end
	assign operating_state_display = disp_ff;
	assign subState = sub_ff;
	assign runEnable = run_ff;
	assign faultNumber = faultNum_ff;
	assign faultLamp = fault_ff;
	assign fault_output_fn = !fault_ff;
	assign drive_status_word = 16'(fault_ff) << SW_FAULT;
	a_fault_outputs: assert property (@(posedge clock) disable iff (!resetn)
		fault_ff |-> !fault_output_fn && drive_status_word[SW_FAULT] && faultLamp)
		else $error("fault outputs wrong");
	a_fault_display: assert property (@(posedge clock) disable iff (!resetn)
		ce && fault_ff |=> operating_state_display == ST_FAULT)
		else $error("fault state not shown");
	a_enable_gate: assert property (@(posedge clock) disable iff (!resetn)
		ce && !controlWord[CW_ENABLE] |=> !runEnable)
		else $error("run without enable bit");
	a_disc_bit: assert property (@(posedge clock) disable iff (!resetn)
		ce && !fault_ff && controlWord[CW_DISCONNECT] |=> operating_state_display == ST_DISC)
		else $error("disconnect not entered");
	a_fstop_bit: assert property (@(posedge clock) disable iff (!resetn)
		ce && fsActive && st.state != ST_FAULT && st.state != ST_DISC |=> operating_state_display == ST_FSTOP)
		else $error("fast stop not entered");
	a_fstop_latch: assert property (@(posedge clock) disable iff (!resetn)
		fsLatch_ff && !shutS |=> fsLatch_ff)
		else $error("fast stop latch lost");
	a_arm_wait: assert property (@(posedge clock) disable iff (!resetn)
		ce && st.state == ST_ARM |=> !runEnable)
		else $error("ran during supply wait");
	a_estop_hold: assert property (@(posedge clock) disable iff (!resetn)
		ce && !fault_ff && estopS != 2'b00 |=> operating_state_display == ST_DISC)
		else $error("emergency stop ignored");
	c_run: cover property (@(posedge clock) runEnable);
	c_fault: cover property (@(posedge clock) fault_ff);
	c_fstop: cover property (@(posedge clock) operating_state_display == ST_FSTOP);
endmodule
`default_nettype wire

/* File: core/drive_seq_pkg.sv */
// constants and types of the drive operating state sequencer
`default_nettype none
package drive_seq_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int VOLT_W = 12;
	localparam int PCT_W = 8;
	localparam int CUR_W = 12;
	localparam int TMR_W = 32;
	localparam int FIELD_NOM_V = 400;
	localparam int PCT_FULL = 100;
	localparam int FIELD_HALF_DIV = 2;
	localparam int CW_SWITCH_ON = 0;
	localparam int CW_DISCONNECT = 1;
	localparam int CW_FAST_STOP = 2;
	localparam int CW_ENABLE = 3;
	localparam int SW_FAULT = 3;
	localparam int INCH_DELAY_MS = 1;
	localparam int INCH_DELAY_CYC = INCH_DELAY_MS * (CLK_HZ / 1000);
	localparam logic [3:0] ST_RUN = 4'h0;
	localparam logic [3:0] ST_READY = 4'h1;
	localparam logic [3:0] ST_TEST = 4'h3;
	localparam logic [3:0] ST_ARM = 4'h4;
	localparam logic [3:0] ST_FIELD = 4'h5;
	localparam logic [3:0] ST_PRECON = 4'h6;
	localparam logic [3:0] ST_SWON = 4'h7;
	localparam logic [3:0] ST_INHIB = 4'h8;
	localparam logic [3:0] ST_FSTOP = 4'h9;
	localparam logic [3:0] ST_DISC = 4'hA;
	localparam logic [3:0] ST_FAULT = 4'hB;
	typedef enum logic [1:0] {PH_IDLE, PH_ARM, PH_FIELD, PH_DONE} phase_t;
	typedef struct packed {
		logic [3:0] state;
		logic [2:0] sub;
	} opstate_t;
endpackage
`default_nettype wire

/* File: core/seq_timer.sv */
// run-time counter that flags when a loaded limit has elapsed
`default_nettype none
module seq_timer
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	delay_if.timer tmr
);
	import drive_seq_pkg::*;
	logic [TMR_W-1:0] count_ff, nxt_count;
	logic done_ff, nxt_done;
	always_comb
	begin
		nxt_count = count_ff;
		nxt_done = done_ff;
		if (tmr.start || !tmr.run)
		begin
			nxt_count = '0;
			nxt_done = 1'b0;
		end
		else if (count_ff >= tmr.limit)
			nxt_done = 1'b1;
		else
			nxt_count = count_ff + 32'h1;
	end
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			count_ff <= '0;
			done_ff <= 1'b0;
		end
		else if (ce)
		begin
			count_ff <= nxt_count;
			done_ff <= nxt_done;
		end
	end
	assign tmr.expired = done_ff;
endmodule
`default_nettype wire

/* File: core/sync2.sv */
// two-stage synchroniser for a bus of pin levels
`default_nettype none
module sync2 #(parameter int W = 1)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff, sync_ff;
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end
	assign q = sync_ff;
endmodule
`default_nettype wire

/* File: verif/drive_operating_state_sequencer_tb.sv */
// self-checking bench of the drive operating state sequencer
`default_nettype none
module drive_operating_state_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import drive_seq_pkg::*;
	localparam int BRAKE = 8;
	logic clock, resetn, ce, wantOn, wantOff2, wantOff3, wantRun;
	logic swPin, enPin, fsPin, dcPin, ccPin, frbPin, extOkPin, extFn, ccFn, frbFn;
	logic thySel, thyDone, symDone, auxOn, shutCmd, intShut, inching, revPend, optRun, optDone;
	logic peerSel, peerOk, l0Ok, l1Ok, faultEv, lamp, faultOut, runEn;
	logic [1:0] estopPin;
	logic [3:0] controlWord, display;
	logic [2:0] sub;
	logic [VOLT_W-1:0] armV, fldV, nomV;
	logic [PCT_W-1:0] uvPct;
	logic [CUR_W-1:0] fldI, fldSp, rampSp, swThr;
	logic [15:0] l0To, l1To, statusWord;
	logic [7:0] faultCode, faultNum;
	logic [31:0] rng;
	int errors, tests_run, n;
	host_ctrl_model i_host (.clock(clock), .resetn(resetn), .wantOn(wantOn), .wantOff2(wantOff2),
		.wantOff3(wantOff3), .wantRun(wantRun), .controlWord(controlWord));
	drive_operating_state_sequencer #(.SUPPLY_WAIT_CYC(200), .AUX_DELAY_CYC(8), .BRAKE_DELAY_CYC(BRAKE),
		.INCH_CYC(8)) i_dut (.clock(clock), .resetn(resetn), .ce(ce), .controlWord(controlWord),
		.switchOnPin(swPin), .enablePin(enPin), .fastStopPin(fsPin), .disconnectPin(dcPin),
		.emergencyStopPin(estopPin), .contactorCheckbackPin(ccPin), .fieldReversalBrakePin(frbPin),
		.externalFieldOkPin(extOkPin), .external_field_check_input_fn(extFn),
		.contactor_checkback_input_fn(ccFn), .field_reversal_brake_input_fn(frbFn),
		.armatureVolts(armV), .fieldVolts(fldV), .nominal_armature_supply_voltage(nomV),
		.undervoltage_threshold_percent(uvPct), .fieldCurrent(fldI), .fieldSetpoint(fldSp),
		.rampInputSetpoint(rampSp), .setpoint_switch_on_threshold(swThr), .thyristorCheckSelect(thySel),
		.thyristorCheckDone(thyDone), .symmetryCheckDone(symDone), .auxiliariesOn(auxOn),
		.shutdownCmd(shutCmd), .internalShutdown(intShut), .inchingActive(inching),
		.fieldReversalPending(revPend), .optimizationRun(optRun), .optimizationDone(optDone),
		.peer_link_select_a(peerSel), .peerTelegramValid(peerOk), .link0_telegram_timeout(l0To),
		.link1_telegram_timeout(l1To), .link0TelegramValid(l0Ok), .link1TelegramValid(l1Ok),
		.faultEvent(faultEv), .faultCode(faultCode), .operating_state_display(display),
		.subState(sub), .faultNumber(faultNum), .faultLamp(lamp), .fault_output_fn(faultOut),
		.drive_status_word(statusWord), .runEnable(runEn));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic armOk(input logic [VOLT_W-1:0] v);
		return (32'(v) * PCT_FULL) > (32'(nomV) * 32'(uvPct));
	endfunction
	function automatic logic fieldOk(input logic [CUR_W-1:0] i, input logic [CUR_W-1:0] sp);
		return (32'(i) * FIELD_HALF_DIV) > 32'(sp);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// polls every cycle so short transient states are not missed
	task automatic waitFor(input logic [3:0] st, input int lim);
		n = 0;
		#1;
		while (display !== st && n < lim)
		begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask
	task automatic expectSt(input logic [3:0] st, input logic [2:0] sb);
		waitFor(st, 60);
		check(16'(display), 16'(st));
		check(16'(sub), 16'(sb));
	endtask
	task automatic good();
		// no telegrams until a scenario sends one, as the seen flags are sticky
		{ce, wantRun, enPin, extOkPin, thySel, thyDone, symDone, auxOn} <= '1;
		{wantOff2, wantOff3, fsPin, dcPin, ccPin, frbPin, extFn, ccFn, frbFn, l0Ok, l1Ok} <= '0;
		{intShut, inching, revPend, optRun, optDone, peerSel, peerOk, faultEv} <= '0;
		estopPin <= 2'h0;
		{l0To, l1To, faultCode} <= '0;
		{nomV, uvPct, armV, fldV} <= {12'h1F4, 8'h50, 12'h320, 12'h190};
		{fldI, fldSp, rampSp, swThr} <= {12'h0C8, 12'h0C8, 12'h000, 12'h064};
	endtask
	task automatic doReset();
		resetn <= 1'b0;
		good();
		{wantOn, swPin, shutCmd} <= 3'b110;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		#1;
		check(16'(display), 16'(ST_FAULT));
		check(16'(runEn), 16'h0);
		// inhibit is set out of reset, so a shutdown is needed first
		recover();
	endtask
	// switch-on is withdrawn and shutdown given, which also acknowledges any inhibit
	task automatic recover();
		@(posedge clock);
		good();
		{wantOn, swPin, shutCmd} <= 3'b001;
		repeat (4) @(posedge clock);
		{wantOn, swPin, shutCmd} <= 3'b110;
		waitFor(ST_RUN, 200);
		check(16'(display), 16'(ST_RUN));
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		#400000;
		errors++;
		test_done();
	end
	initial
	begin
		errors = 0;
		tests_run = 0;
		rng = 32'hD464CF2A;
		doReset();
		check(16'(runEn), 16'h1);
		for (int i = 0; i < 16; i++)
		begin
			rng = xs(rng);
			@(posedge clock);
			if (i < 8)
				armV <= 12'(398 + rng % 5);
			else
				{fldSp, fldI} <= {12'(100 + rng % 400), 12'(50 + rng % 210)};
			#1;
			if (i < 8 && !armOk(armV))
				expectSt(ST_ARM, 3'h0);
			else if (i >= 8 && !fieldOk(fldI, fldSp))
				expectSt(ST_FIELD, 3'h0);
			recover();
		end
		$display("test supply and field thresholds done");
		for (int i = 0; i < 11; i++)
		begin
			@(posedge clock);
			case (i)
				0: thyDone <= 1'b0;
				1: symDone <= 1'b0;
				2: fldV <= 12'h140;
				3: {extFn, extOkPin} <= 2'b10;
				4: auxOn <= 1'b0;
				5: rampSp <= 12'h065;
				6: {enPin, wantRun} <= 2'b01;
				7: {enPin, wantRun} <= 2'b10;
				8: revPend <= 1'b1;
				9: optRun <= 1'b1;
				default: ccFn <= 1'b1;
			endcase
			case (i)
				0: expectSt(ST_TEST, 3'h0);
				1: expectSt(ST_TEST, 3'h1);
				2: expectSt(ST_FIELD, 3'h1);
				3: expectSt(ST_FIELD, 3'h0);
				4: expectSt(ST_PRECON, 3'h0);
				5: expectSt(ST_PRECON, 3'h1);
				6: expectSt(ST_READY, 3'h1);
				7: expectSt(ST_READY, 3'h2);
				8: expectSt(ST_READY, 3'h4);
				9: expectSt(ST_READY, 3'h5);
				default: expectSt(ST_READY, 3'h6);
			endcase
			check(16'(runEn), 16'h0);
			recover();
		end
		@(posedge clock);
		rampSp <= 12'h064;
		#1;
		waitFor(ST_RUN, 60);
		check(16'(display), 16'(ST_RUN));
		@(posedge clock);
		inching <= 1'b1;
		@(posedge clock);
		inching <= 1'b0;
		expectSt(ST_READY, 3'h3);
		recover();
		@(posedge clock);
		enPin <= 1'b0;
		waitFor(ST_READY, 60);
		@(posedge clock);
		enPin <= 1'b1;
		n = 0;
		while (runEn !== 1'b1 && n < 60)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		check(16'(n >= BRAKE && n < 60), 16'h1);
		$display("test ready chain done");
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clock);
			case (i)
				0: dcPin <= 1'b1;
				1: wantOff2 <= 1'b1;
				2: estopPin <= 2'h1;
				3: estopPin <= 2'h2;
				4: peerSel <= 1'b1;
				5: {l1To, l1Ok} <= {16'h0001, 1'b0};
				default: {l0To, l0Ok} <= {16'hFFFF, 1'b0};
			endcase
			expectSt(ST_DISC, 3'(i < 3 ? i : i - 1));
			check(16'(runEn), 16'h0);
			if (i >= 4)
			begin
				@(posedge clock);
				{peerOk, l1Ok, l0Ok} <= 3'(3'b100 >> (i - 4));
				waitFor(ST_RUN, 60);
				check(16'(display), 16'(ST_RUN));
			end
			recover();
		end
		$display("test voltage disconnect done");
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock);
			{fsPin, wantOff3} <= (i == 0) ? 2'b10 : 2'b01;
			expectSt(ST_FSTOP, 3'(i));
			@(posedge clock);
			{fsPin, wantOff3} <= 2'b00;
			repeat (20) @(posedge clock);
			#1;
			check(16'(display), 16'(ST_FSTOP));
			check(16'(sub), 16'h2);
			recover();
		end
		@(posedge clock);
		{wantOn, swPin} <= 2'b00;
		waitFor(ST_SWON, 60);
		check(16'(display), 16'(ST_SWON));
		@(posedge clock);
		wantOn <= 1'b1;
		waitFor(ST_RUN, 60);
		check(16'(display), 16'(ST_RUN));
		@(posedge clock);
		intShut <= 1'b1;
		expectSt(ST_SWON, 3'h2);
		recover();
		@(posedge clock);
		{frbFn, frbPin} <= 2'b11;
		expectSt(ST_SWON, 3'h2);
		@(posedge clock);
		frbPin <= 1'b0;
		waitFor(ST_RUN, 60);
		check(16'(display), 16'(ST_RUN));
		$display("test stop and switch-on done");
		@(posedge clock);
		{faultEv, faultCode} <= {1'b1, 8'h5A};
		waitFor(ST_FAULT, 60);
		@(posedge clock);
		faultEv <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check(16'(display), 16'(ST_FAULT));
		check(16'(faultNum), 16'h005A);
		check(16'({lamp, faultOut, statusWord[SW_FAULT]}), 16'h0005);
		doReset();
		@(posedge clock);
		armV <= 12'h000;
		expectSt(ST_ARM, 3'h0);
		waitFor(ST_FAULT, 400);
		check(16'(n > 150), 16'h1);
		check(16'(display), 16'(ST_FAULT));
		check(16'({lamp, faultOut, statusWord[SW_FAULT]}), 16'h0005);
		$display("test faults done");
		test_done();
	end
endmodule
`default_nettype wire

/* File: verif/host_ctrl_model.sv */
// host side model that turns command requests into the drive control word
`default_nettype none
module host_ctrl_model
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic wantOn,
	input wire logic wantOff2,
	input wire logic wantOff3,
	input wire logic wantRun,
	output logic [3:0] controlWord
);
	timeunit 1ns;
	timeprecision 1ns;
	import drive_seq_pkg::*;
	logic [3:0] word_ff;
	logic [3:0] nxt_word;
	// ----------------------------------------
	// control word, changed only after an edge
	// ----------------------------------------
	always_comb
	begin
		nxt_word = 4'h0;
		nxt_word[CW_SWITCH_ON] = wantOn;
		nxt_word[CW_DISCONNECT] = wantOff2;
		nxt_word[CW_FAST_STOP] = wantOff3;
		nxt_word[CW_ENABLE] = wantRun;
	end
	// word is all off in reset so no command leaks out early
	always_ff @(posedge clock)
		word_ff <= resetn ? nxt_word : 4'h0;
	assign controlWord = word_ff;
endmodule
`default_nettype wire
